//--- common/cdel_pkg.sv
// constants and types of the cartridge disk exception logic
// assumes a 100 MHz system clock and up to four wired drive positions
//
// Behaviour
// - bit 16 marks a result to store; Test returns control ID in 17-23
// - Write to a not ready drive takes one buffer load first
// - not ready ends every operation except Pause and Test
// - normal Read checks every sector check code, no sector indication
// - Read Absolute never checks the sector check code
// - parity errors are reported but never end an operation
// - drive check error on Read counts only during data phase
// - Write parity counts only on target or predecessor; sector skipped
// - after Write parity error remaining write data is still accepted
// - Write to locked drive takes and discards one load, then lockout
// - presence comes from wiring; ready comes from the drive itself
// - address not found in 2 index pulses ends op, clears seek flop
// - no address coincidence check on Write Index or Read Absolute
// - illegal cylinder clears seek flop, seeks cylinder 0, reports
// - 32-sector seek over 200 ms is seek incomplete until next seek
// - seek incomplete in pulse ops or internal seek ends op at once
// - seek incomplete after implicit seek is reported on next op
// - seeking drive reports seeking, flop kept; writes take one load
// - Read or Read Absolute to seeking drive clears bit 16
// - Test to seeking drive reports it without exception bit
// - seek flop set blocks implicit seeks and shows on Test
// - bit 1 is set when bits 2-6, 11 or 14 set, or bit 9 clear on any op but Pause
// - address errors set both bits 10 and 11
package cdel_pkg;

  typedef enum logic [2:0] {
    OP_READ, OP_READ_ABS, OP_WRITE, OP_WRITE_IDX, OP_TEST, OP_PAUSE
  } cdel_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EVAL, ST_LOAD, ST_SEEKW, ST_XFER, ST_FIN, ST_RESP
  } cdel_state_t;

  localparam int unsigned N_UNITS    = 4;
  localparam int unsigned RES_W      = 24;
  // result word bit positions
  localparam int unsigned RB_DONE    = 0;
  localparam int unsigned RB_EXC     = 1;
  localparam int unsigned RB_NRDY    = 2;
  localparam int unsigned RB_PAR_RD  = 3;
  localparam int unsigned RB_PAR_DRV = 4;
  localparam int unsigned RB_PAR_MEM = 5;
  localparam int unsigned RB_WLOCK   = 6;
  localparam int unsigned RB_UID_LO  = 7;
  localparam int unsigned RB_PRES    = 9;
  localparam int unsigned RB_SAE_LO  = 10;
  localparam int unsigned RB_SAE_HI  = 11;
  localparam int unsigned RB_NSEEK   = 12;
  localparam int unsigned RB_SEEKING = 13;
  localparam int unsigned RB_SSFF    = 14;
  localparam int unsigned RB_STORE   = 16;
  localparam int unsigned RB_CID_LO  = 17;

  localparam logic [1:0]  IDX_LIMIT  = 2'h2;
  localparam logic [23:0] RESULT_RST = 24'h000000;
  // arbitrary neutral control identification value
  localparam logic [6:0]  CTRL_ID_DFLT = 7'h2b;

  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SEEK_TO_MS  = 200;
  localparam int unsigned SEEK_TO_CYC = SEEK_TO_MS * CLK_MHZ * 1000;
  localparam int unsigned TMR_W       = 25;

endpackage

//--- common/cdel_seek_if.sv
// per-drive seek tracking signals between controller and tracker
// assumes both ends run on the system clock
interface cdel_seek_if;
  logic start;
  logic set_ff;
  logic clr_ff;
  logic sect32;
  logic on_cyl;
  logic stat_ff;
  logic seeking;
  logic seek_inc;
  modport ctl (output start, set_ff, clr_ff, sect32, on_cyl,
               input  stat_ff, seeking, seek_inc);
  modport trk (input  start, set_ff, clr_ff, sect32, on_cyl,
               output stat_ff, seeking, seek_inc);
endinterface

//--- hdl/cdel_seek_trk.sv
// seek status flop, seek timer and seek incomplete flag of one drive
// assumes on_cyl rises once when the drive reaches the sought cylinder
module cdel_seek_trk
  import cdel_pkg::*;
#(
  parameter int unsigned TO_CYC = SEEK_TO_CYC
)(
  input  wire logic  clk_i,
  input  wire logic  rst_ni,
  cdel_seek_if.trk   sk
);

  if (TO_CYC < 1 || TO_CYC >= (1 << TMR_W)) begin : g_bad_to
    $error("seek timeout count out of range");
  end

  localparam logic [TMR_W-1:0] TO_LAST = TMR_W'(TO_CYC - 1);

  logic [TMR_W-1:0] tmr_reg;
  logic             seeking_reg;
  logic             inc_reg;
  logic             stat_reg;
  logic             on_cyl_q;
  logic             timeout;

  assign timeout = seeking_reg && (tmr_reg == TO_LAST);

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      on_cyl_q <= 1'b0;
    end else begin
      on_cyl_q <= sk.on_cyl;
    end
  end

  // a rising on-cylinder ends the seek; a drive left on cylinder
  // ends it only by the timer
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      seeking_reg <= 1'b0;
      tmr_reg     <= '0;
    end else if (sk.start) begin
      seeking_reg <= 1'b1;
      tmr_reg     <= '0;
    end else begin
      if ((sk.on_cyl && !on_cyl_q) || timeout) begin
        seeking_reg <= 1'b0;
      end
      if (seeking_reg) begin
        tmr_reg <= tmr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      inc_reg <= 1'b0;
    end else if (sk.start) begin
      inc_reg <= 1'b0;
    end else if (timeout && sk.sect32) begin
      inc_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      stat_reg <= 1'b0;
    end else if (sk.set_ff) begin
      stat_reg <= 1'b1;
    end else if (sk.clr_ff) begin
      stat_reg <= 1'b0;
    end
  end

  assign sk.stat_ff  = stat_reg;
  assign sk.seeking  = seeking_reg;
  assign sk.seek_inc = inc_reg;

endmodule

//--- hdl/cdel_top.sv
// exception and result logic of the cartridge disk controller
// assumes the data path moves sectors and reports events as pulses
module cdel_top
  import cdel_pkg::*;
#(
  parameter int unsigned SEEK_TO_CYC_P = SEEK_TO_CYC,
  // arbitrary neutral control identification value
  parameter logic [6:0]  CTRL_ID       = CTRL_ID_DFLT
)(
  input  wire logic               SYS_CLK_I,
  input  wire logic               RESETN_I,
  input  wire logic               OP_VALID_I,
  input  wire cdel_op_t           OP_CODE_I,
  input  wire logic [1:0]         OP_UNIT_I,
  input  wire logic               OP_NEED_SEEK_I,
  output logic                    OP_READY_O,
  input  wire logic               WR_VALID_I,
  input  wire logic               WR_LAST_I,
  output logic                    WR_READY_O,
  input  wire logic               TERMINATE_I,
  input  wire logic               MEM_PARITY_I,
  output logic                    RESULT_VALID_O,
  output logic [RES_W-1:0]        RESULT_O,
  input  wire logic [N_UNITS-1:0] UNIT_WIRED_I,
  input  wire logic [7:0]         UNIT_TYPE_I,
  input  wire logic [N_UNITS-1:0] DRV_READY_I,
  input  wire logic [N_UNITS-1:0] DRV_WLOCK_I,
  input  wire logic [N_UNITS-1:0] DRV_ON_CYL_I,
  input  wire logic               INDEX_PULSE_I,
  input  wire logic               ADDR_FOUND_I,
  input  wire logic               SECT_END_I,
  input  wire logic               SECT_CODE_ERR_I,
  input  wire logic               DRV_CHECK_ERR_I,
  input  wire logic               DATA_PHASE_I,
  input  wire logic               WR_TARGET_I,
  input  wire logic               CYL_ILLEGAL_I,
  input  wire logic               CYL_CROSS_I,
  output logic                    XFER_GO_O,
  output logic                    SKIP_SECTOR_O,
  output logic                    SEEK_REQ_O,
  output logic [1:0]              SEEK_UNIT_O,
  output logic                    SEEK_CYL0_O
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // state

  cdel_state_t state_reg;
  cdel_state_t state_next;
  cdel_op_t    op_reg;
  logic [1:0]  unit_reg;
  logic        need_seek_reg;
  logic        found_reg;
  logic [1:0]  idx_cnt_reg;
  logic        f_nr_reg, f_prd_reg, f_pdrv_reg, f_pmem_reg;
  logic        f_wl_reg, f_sae_reg, f_seek_reg, f_nostore_reg;

  logic [N_UNITS-1:0] stat_v, seeking_v, inc_v;
  logic u_ready, u_wl, u_pres, u_stat, u_seeking, u_inc;
  logic is_rd, is_wr, pulse_op, take_op;

  // set in the decision logic below
  logic seek_go, seek_set, seek_cyl0, ff_clr;
  logic set_nr, set_sae, set_seek, set_nostore, set_wl;

  assign u_ready   = DRV_READY_I[unit_reg];
  assign u_wl      = DRV_WLOCK_I[unit_reg];
  assign u_pres    = UNIT_WIRED_I[unit_reg];
  assign u_stat    = stat_v[unit_reg];
  assign u_seeking = seeking_v[unit_reg];
  assign u_inc     = inc_v[unit_reg];

  assign is_rd    = (op_reg == OP_READ) || (op_reg == OP_READ_ABS);
  assign is_wr    = (op_reg == OP_WRITE) || (op_reg == OP_WRITE_IDX);
  assign pulse_op = (op_reg == OP_READ_ABS) || (op_reg == OP_WRITE_IDX);
  assign take_op  = OP_VALID_I && (state_reg == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // per-drive seek trackers

  cdel_seek_if sk [N_UNITS] ();

  for (genvar g = 0; g < N_UNITS; g++) begin : g_unit
    assign sk[g].start  = seek_go && (unit_reg == 2'(g));
    assign sk[g].set_ff = seek_set && (unit_reg == 2'(g));
    assign sk[g].clr_ff = ff_clr && (unit_reg == 2'(g));
    // high unit-type bit clear means a 32-sector drive
    assign sk[g].sect32 = !UNIT_TYPE_I[2*g+1];
    assign sk[g].on_cyl = DRV_ON_CYL_I[g];
    assign stat_v[g]    = sk[g].stat_ff;
    assign seeking_v[g] = sk[g].seeking;
    assign inc_v[g]     = sk[g].seek_inc;
    cdel_seek_trk #(
      .TO_CYC (SEEK_TO_CYC_P)
    ) u_trk (
      .clk_i  (SYS_CLK_I),
      .rst_ni (rst_n),
      .sk     (sk[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // decision and sequencing

  always_comb begin
    state_next  = state_reg;
    seek_go     = 1'b0;
    seek_set    = 1'b0;
    seek_cyl0   = 1'b0;
    ff_clr      = 1'b0;
    set_nr      = 1'b0;
    set_sae     = 1'b0;
    set_seek    = 1'b0;
    set_nostore = 1'b0;
    set_wl      = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (OP_VALID_I) begin
          state_next = ST_EVAL;
        end
      end
      ST_EVAL: begin
        if (op_reg == OP_PAUSE) begin
          set_nostore = 1'b1;
          state_next  = ST_FIN;
        end else if (!u_ready && op_reg != OP_TEST) begin
          set_nr     = 1'b1;
          state_next = is_wr ? ST_LOAD : ST_FIN;
        end else if (u_inc) begin
          set_sae    = 1'b1;
          ff_clr     = 1'b1;
          seek_go    = 1'b1;
          seek_cyl0  = 1'b1;
          state_next = ST_FIN;
        end else if (op_reg == OP_TEST) begin
          state_next = ST_FIN;
        end else if (u_seeking) begin
          set_seek    = 1'b1;
          set_nostore = is_rd;
          state_next  = is_wr ? ST_LOAD : ST_FIN;
        end else if (u_wl && is_wr) begin
          set_wl     = 1'b1;
          state_next = ST_LOAD;
        end else if (pulse_op) begin
          // pulse-located ops always seek first
          seek_go    = 1'b1;
          seek_set   = 1'b1;
          state_next = ST_SEEKW;
        end else if (need_seek_reg && !u_stat) begin
          // implicit seek: op answers as seeking, drive goes on alone
          seek_go     = 1'b1;
          seek_set    = 1'b1;
          set_seek    = 1'b1;
          set_nostore = is_rd;
          state_next  = is_wr ? ST_LOAD : ST_FIN;
        end else begin
          state_next = ST_XFER;
        end
      end
      ST_LOAD: begin
        if (WR_VALID_I && WR_LAST_I) begin
          state_next = ST_FIN;
        end
      end
      ST_SEEKW: begin
        if (u_inc) begin
          set_sae    = 1'b1;
          ff_clr     = 1'b1;
          seek_go    = 1'b1;
          seek_cyl0  = 1'b1;
          state_next = ST_FIN;
        end else if (!u_seeking) begin
          state_next = ST_XFER;
        end
      end
      ST_XFER: begin
        if (CYL_ILLEGAL_I) begin
          set_sae    = 1'b1;
          ff_clr     = 1'b1;
          seek_go    = 1'b1;
          seek_cyl0  = 1'b1;
          state_next = ST_FIN;
        end else if (!u_ready) begin
          set_nr     = 1'b1;
          state_next = ST_FIN;
        end else if (!pulse_op && !found_reg && INDEX_PULSE_I &&
                     idx_cnt_reg == IDX_LIMIT - 2'h1) begin
          set_sae    = 1'b1;
          ff_clr     = 1'b1;
          state_next = ST_FIN;
        end else if (TERMINATE_I) begin
          state_next = ST_FIN;
        end else if (CYL_CROSS_I) begin
          // internal seek of a multi-cylinder transfer
          seek_go    = 1'b1;
          seek_set   = 1'b1;
          state_next = ST_SEEKW;
        end
      end
      ST_FIN: begin
        state_next = ST_RESP;
      end
      ST_RESP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      op_reg        <= OP_PAUSE;
      unit_reg      <= 2'h0;
      need_seek_reg <= 1'b0;
    end else if (take_op) begin
      op_reg        <= OP_CODE_I;
      unit_reg      <= OP_UNIT_I;
      need_seek_reg <= OP_NEED_SEEK_I;
    end
  end

  // address search: a cylinder crossing starts a fresh search
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      found_reg   <= 1'b0;
      idx_cnt_reg <= 2'h0;
    end else if (take_op || state_reg == ST_SEEKW) begin
      found_reg   <= 1'b0;
      idx_cnt_reg <= 2'h0;
    end else if (state_reg == ST_XFER) begin
      if (ADDR_FOUND_I) begin
        found_reg <= 1'b1;
      end
      if (INDEX_PULSE_I && !found_reg) begin
        idx_cnt_reg <= idx_cnt_reg + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // exception flags

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      f_nr_reg      <= 1'b0;
      f_sae_reg     <= 1'b0;
      f_seek_reg    <= 1'b0;
      f_nostore_reg <= 1'b0;
      f_wl_reg      <= 1'b0;
    end else if (take_op) begin
      f_nr_reg      <= 1'b0;
      f_sae_reg     <= 1'b0;
      f_seek_reg    <= 1'b0;
      f_nostore_reg <= 1'b0;
      f_wl_reg      <= 1'b0;
    end else begin
      f_nr_reg      <= f_nr_reg | set_nr;
      f_sae_reg     <= f_sae_reg | set_sae;
      f_seek_reg    <= f_seek_reg | set_seek;
      f_nostore_reg <= f_nostore_reg | set_nostore;
      f_wl_reg      <= f_wl_reg | set_wl;
    end
  end

  // parity only flags, never ends the op
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      f_prd_reg  <= 1'b0;
      f_pdrv_reg <= 1'b0;
      f_pmem_reg <= 1'b0;
    end else if (take_op) begin
      f_prd_reg  <= 1'b0;
      f_pdrv_reg <= 1'b0;
      f_pmem_reg <= 1'b0;
    end else if (state_reg == ST_XFER) begin
      if (op_reg == OP_READ && SECT_END_I && SECT_CODE_ERR_I) begin
        f_prd_reg <= 1'b1;
      end
      if (DRV_CHECK_ERR_I && (is_rd ? DATA_PHASE_I : WR_TARGET_I)) begin
        f_pdrv_reg <= 1'b1;
      end
      if (MEM_PARITY_I && is_wr) begin
        f_pmem_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      SKIP_SECTOR_O <= 1'b0;
    end else begin
      SKIP_SECTOR_O <= (state_reg == ST_XFER) && is_wr &&
                       DRV_CHECK_ERR_I && WR_TARGET_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // seek commands toward the drives

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      SEEK_REQ_O  <= 1'b0;
      SEEK_UNIT_O <= 2'h0;
      SEEK_CYL0_O <= 1'b0;
    end else begin
      SEEK_REQ_O <= seek_go;
      if (seek_go) begin
        SEEK_UNIT_O <= unit_reg;
        SEEK_CYL0_O <= seek_cyl0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result word

  logic [RES_W-1:0] res;
  logic             is_test;

  assign is_test = (op_reg == OP_TEST);

  always_comb begin
    res                = RESULT_RST;
    res[RB_DONE]       = 1'b1;
    res[RB_NRDY]       = f_nr_reg | (is_test & !u_ready);
    res[RB_PAR_RD]     = f_prd_reg;
    res[RB_PAR_DRV]    = f_pdrv_reg;
    res[RB_PAR_MEM]    = f_pmem_reg;
    res[RB_WLOCK]      = f_wl_reg | (is_test & u_wl);
    res[RB_PRES]       = u_pres & (op_reg != OP_PAUSE);
    res[RB_SAE_LO]     = f_sae_reg;
    res[RB_SAE_HI]     = f_sae_reg;
    res[RB_SEEKING]    = f_seek_reg;
    res[RB_NSEEK]      = is_test & !u_seeking;
    res[RB_SSFF]       = is_test & u_stat;
    res[RB_STORE]      = !f_nostore_reg;
    if (is_test) begin
      res[RB_UID_LO+1:RB_UID_LO] = UNIT_TYPE_I[2*unit_reg +: 2];
      res[RB_CID_LO+6:RB_CID_LO] = CTRL_ID;
    end
    res[RB_EXC] = (|res[RB_WLOCK:RB_NRDY]) | res[RB_SAE_HI] |
                  res[RB_SSFF] | ((op_reg != OP_PAUSE) & !res[RB_PRES]);
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RESULT_O <= RESULT_RST;
    end else if (state_reg == ST_FIN) begin
      RESULT_O <= res;
    end
  end

  // write data accepted to the end
  assign WR_READY_O = (state_reg == ST_LOAD) ||
                      ((state_reg == ST_XFER) && is_wr);
  assign OP_READY_O     = (state_reg == ST_IDLE);
  assign RESULT_VALID_O = (state_reg == ST_RESP);
  assign XFER_GO_O      = (state_reg == ST_XFER);

endmodule

//--- verification/cdel_assertions.sv
// assertions on the result word and operation handshake of cdel_top
// assumes it is bound to cdel_top and sees its ports only
module cdel_assertions
  import cdel_pkg::*;
#(
  parameter logic [6:0] CTRL_ID = CTRL_ID_DFLT
)(
  input wire logic               SYS_CLK_I,
  input wire logic               RESETN_I,
  input wire logic               OP_VALID_I,
  input wire cdel_op_t           OP_CODE_I,
  input wire logic [1:0]         OP_UNIT_I,
  input wire logic               OP_READY_O,
  input wire logic               RESULT_VALID_O,
  input wire logic [RES_W-1:0]   RESULT_O,
  input wire logic [N_UNITS-1:0] UNIT_WIRED_I
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  cdel_op_t   op_reg;
  logic [1:0] unit_reg;
  logic       take;
  logic       fin;
  assign take = OP_VALID_I && OP_READY_O;
  assign fin  = RESULT_VALID_O;
  // the result word is judged against the operation that asked for it
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      op_reg   <= OP_PAUSE;
      unit_reg <= 2'h0;
    end else if (take) begin
      op_reg   <= OP_CODE_I;
      unit_reg <= OP_UNIT_I;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_TEST_LAT:
    assert property (take && OP_CODE_I == OP_TEST |=> !fin[*2] ##1 fin)
    else $error("test result not on third cycle");
  AST_TEST_ID:
    assert property (fin && op_reg == OP_TEST |-> RESULT_O[RB_STORE]
      && RESULT_O[23:17] == CTRL_ID) else $error("test id or store bit");
  AST_PRES:
    assert property (fin && op_reg == OP_TEST |->
      RESULT_O[RB_PRES] == UNIT_WIRED_I[unit_reg]) else $error("presence");
  AST_PAUSE:
    assert property (fin && op_reg == OP_PAUSE |-> !RESULT_O[RB_STORE])
    else $error("pause result marked for storing");
  AST_EXC:
    assert property (fin && (|RESULT_O[6:2] || RESULT_O[11] || RESULT_O[14]
      || (op_reg != OP_PAUSE && !RESULT_O[RB_PRES])) |-> RESULT_O[RB_EXC])
      else $error("exception bit missing");
  AST_SAE:
    assert property (fin |-> RESULT_O[RB_SAE_LO] == RESULT_O[RB_SAE_HI])
    else $error("address error bits split");
  AST_SEEK_RD:
    assert property (fin && RESULT_O[RB_SEEKING] && (op_reg == OP_READ
      || op_reg == OP_READ_ABS) |-> !RESULT_O[RB_STORE])
    else $error("seeking read marked for storing");
  AST_PULSE:
    assert property (fin |=> !fin) else $error("result pulse too long");
endmodule

bind cdel_top cdel_assertions #(.CTRL_ID(CTRL_ID)) i_cdel_assertions (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .OP_VALID_I(OP_VALID_I),
  .OP_CODE_I(OP_CODE_I), .OP_UNIT_I(OP_UNIT_I), .OP_READY_O(OP_READY_O),
  .RESULT_VALID_O(RESULT_VALID_O), .RESULT_O(RESULT_O),
  .UNIT_WIRED_I(UNIT_WIRED_I));

//--- verification/cdel_drv_model.sv
// stand-in for four drives: head positioning and index pulses
// assumes seek requests are one-cycle pulses naming one drive
module cdel_drv_model (
  input  wire logic       clk_i,
  input  wire logic       seek_req_i,
  input  wire logic [1:0] seek_unit_i,
  input  wire logic [3:0] stuck_i,
  output logic      [3:0] on_cyl_o,
  output logic            index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cyl_reg = 4'hf;
  logic [3:0] idx_reg = 4'h0;
  logic [3:0] cnt_reg [4] = '{default: 4'h0};
  assign on_cyl_o = cyl_reg;
  assign index_o  = idx_reg == 4'hf;
  always @(posedge clk_i) idx_reg <= idx_reg + 4'h1;
  always @(posedge clk_i) begin
    for (int u = 0; u < 4; u++) begin
      if (seek_req_i && seek_unit_i == 2'(u)) begin
        cyl_reg[u] <= 1'b0;
        cnt_reg[u] <= 4'h8;
      end else if (cnt_reg[u] != 4'h0) begin
        cnt_reg[u] <= cnt_reg[u] - 4'h1;
        cyl_reg[u] <= cnt_reg[u] == 4'h1 && !stuck_i[u];
      end
    end
  end
endmodule

//--- verification/tb.sv
// self-checking bench of cdel_top beside a drive stand-in
// assumes the checker binds itself; seek timeout shortened to 50 cycles
module tb;
  import cdel_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, need_seek = 1'b0;
  logic wr_valid = 1'b0, wr_last = 1'b0, term = 1'b0, mem_par = 1'b0;
  logic found = 1'b0, sect_end = 1'b0, code_err = 1'b0, chk_err = 1'b0;
  logic dph = 1'b0, cill = 1'b0, sawsk = 1'b0;
  logic op_ready, wr_ready, res_v, go, skip, sreq, scyl0, idx, saw0;
  cdel_op_t op_code = OP_TEST;
  logic [1:0] op_unit = 2'h0, seek_unit, u;
  logic [3:0] wired = 4'hf, rdy = 4'hf, wlock = 4'h0, stuck = 4'h0, on_cyl;
  logic [7:0] utype = 8'h00;
  logic [15:0] rnd = 16'h0785;
  logic [RES_W-1:0] res, r;
  int checks = 0, miscompares = 0, wcnt;
  initial forever #5 clk = ~clk;
  cdel_top #(.SEEK_TO_CYC_P(50)) i_cdel_top (
    .SYS_CLK_I(clk), .RESETN_I(rst_n), .OP_VALID_I(op_valid),
    .OP_CODE_I(op_code), .OP_UNIT_I(op_unit), .OP_NEED_SEEK_I(need_seek),
    .OP_READY_O(op_ready), .WR_VALID_I(wr_valid), .WR_LAST_I(wr_last),
    .WR_READY_O(wr_ready), .TERMINATE_I(term), .MEM_PARITY_I(mem_par),
    .RESULT_VALID_O(res_v), .RESULT_O(res), .UNIT_WIRED_I(wired),
    .UNIT_TYPE_I(utype), .DRV_READY_I(rdy), .DRV_WLOCK_I(wlock),
    .DRV_ON_CYL_I(on_cyl), .INDEX_PULSE_I(idx), .ADDR_FOUND_I(found),
    .SECT_END_I(sect_end), .SECT_CODE_ERR_I(code_err),
    .DRV_CHECK_ERR_I(chk_err), .DATA_PHASE_I(dph), .WR_TARGET_I(dph),
    .CYL_ILLEGAL_I(cill), .CYL_CROSS_I(1'b0), .XFER_GO_O(go),
    .SKIP_SECTOR_O(skip), .SEEK_REQ_O(sreq), .SEEK_UNIT_O(seek_unit),
    .SEEK_CYL0_O(scyl0));
  cdel_drv_model i_cdel_drv_model (.clk_i(clk), .seek_req_i(sreq),
    .seek_unit_i(seek_unit), .stuck_i(stuck), .on_cyl_o(on_cyl),
    .index_o(idx));
  always @(negedge clk) begin
    if (sreq && scyl0) saw0 = 1'b1;
    if (skip) sawsk = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one operation; write data is offered whole loads of one word each,
  // terminate comes after ta cycles of transfer (0 = never)
  task automatic run_op(input cdel_op_t c, input logic [1:0] un,
                        input logic sk, input int ta, input logic af);
    int n;
    int xn;
    logic tk;
    logic x;
    n = 0;
    xn = 0;
    wcnt = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_unit <= un;
    need_seek <= sk;
    wr_valid <= 1'b1;
    wr_last <= 1'b1;
    @(negedge clk);
    while (res_v !== 1'b1 && n < 400) begin
      tk = op_valid && op_ready;
      x = go;
      if (wr_valid && wr_ready) wcnt++;
      @(posedge clk);
      if (tk) op_valid <= 1'b0;
      xn = x ? xn + 1 : 0;
      term <= ta != 0 && xn == ta;
      found <= af && x;
      {sect_end, code_err, chk_err, mem_par} <= {4{x}};
      n++;
      @(negedge clk);
    end
    r = res;
    chk(n < 400, "no result");
    @(posedge clk);
    {op_valid, wr_valid, wr_last, term} <= 4'h0;
    {found, sect_end, code_err, chk_err, mem_par} <= 5'h00;
  endtask
  initial begin
    #100us;
    chk(1'b0, "watchdog");
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      u = rnd[9:8];
      wired <= rnd[3:0];
      rdy <= rnd[7:4];
      utype <= rnd[15:8];
      run_op(OP_TEST, u, 1'b0, 0, 1'b0);
      chk(r[RB_PRES] === wired[u] && r[RB_NRDY] === ~rdy[u], "pr");
      chk(r[RB_STORE] === 1'b1 && r[23:17] === CTRL_ID_DFLT, "id");
    end
    // unit 0 not ready, unit 2 locked, all drives 32-sector
    wired <= 4'hf;
    rdy <= 4'he;
    wlock <= 4'h4;
    utype <= 8'h00;
    run_op(OP_WRITE, 2'h0, 1'b0, 0, 1'b0);
    chk(r[2:1] === 2'h3 && wcnt > 0, "not ready write");
    run_op(OP_READ, 2'h0, 1'b0, 0, 1'b0);
    chk(r[2:1] === 2'h3, "not ready read");
    run_op(OP_WRITE, 2'h2, 1'b0, 0, 1'b0);
    chk(r[RB_WLOCK] === 1'b1 && r[1] === 1'b1 && wcnt > 0, "lock");
    run_op(OP_PAUSE, 2'h1, 1'b0, 0, 1'b0);
    chk(r[RB_STORE] === 1'b0, "pause");
    run_op(OP_READ, 2'h1, 1'b0, 6, 1'b1);
    chk(r[RB_PAR_RD] === 1'b1 && r[11:10] === 2'h0, "read code");
    chk(r[RB_PAR_DRV] === 1'b0, "check outside data");
    run_op(OP_READ, 2'h1, 1'b0, 0, 1'b0);
    chk(r[11:10] === 2'h3 && r[1] === 1'b1, "coincidence");
    run_op(OP_READ_ABS, 2'h1, 1'b1, 6, 1'b0);
    chk(r[11:10] === 2'h0, "abs coincidence");
    chk(r[RB_PAR_RD] === 1'b0, "abs code");
    run_op(OP_TEST, 2'h1, 1'b0, 0, 1'b0);
    chk(r[RB_SSFF] === 1'b1, "seek flop");
    run_op(OP_WRITE, 2'h3, 1'b0, 5, 1'b1);
    chk(r[RB_PAR_MEM] === 1'b1 && wcnt > 4, "mem parity");
    // drive check errors on the target sector and in the data phase
    dph <= 1'b1;
    run_op(OP_WRITE, 2'h1, 1'b0, 5, 1'b1);
    chk(r[RB_PAR_DRV] === 1'b1 && sawsk === 1'b1, "target");
    chk(wcnt > 4, "data after parity");
    run_op(OP_READ, 2'h1, 1'b0, 6, 1'b1);
    chk(r[RB_PAR_DRV] === 1'b1, "check in data");
    saw0 = 1'b0;
    cill <= 1'b1;
    run_op(OP_READ, 2'h1, 1'b0, 0, 1'b1);
    chk(r[11:10] === 2'h3 && saw0 === 1'b1, "illegal address");
    {dph, cill} <= 2'h0;
    stuck <= 4'hc;
    run_op(OP_READ, 2'h2, 1'b1, 0, 1'b0);
    chk(r[RB_STORE] === 1'b0, "seeking read");
    repeat (70) @(posedge clk);
    run_op(OP_TEST, 2'h2, 1'b0, 0, 1'b0);
    chk(r[11:10] === 2'h3, "late seek incomplete");
    saw0 = 1'b0;
    run_op(OP_WRITE_IDX, 2'h3, 1'b1, 0, 1'b0);
    repeat (3) @(posedge clk);
    chk(r[11:10] === 2'h3 && saw0 === 1'b1, "seek incomplete");
    wrap_up();
  end
endmodule
